// File: verification/sasp_chk.sv
// Concurrent checks on the serial audio port top
`timescale 1ns/100ps
module sasp_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sys_clk_in,
  input wire logic [1:0] iface_mode_field,
  input wire logic bit_clk_oe,
  input wire logic frame_clk_oe,
  input wire logic data_out,
  input wire logic sync_lost,
  input wire logic in_reset,
  input wire logic powered_down
);
  logic sys_reg;
  logic [9:0] idle_reg;
  logic [10:0] edge_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Idle span of the system clock; saturates so a long halt never wraps
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sys_reg <= 1'b0;
      idle_reg <= 10'h000;
    end else begin
      sys_reg <= sys_clk_in;
      if (sys_reg != sys_clk_in) begin
        idle_reg <= 10'h000;
      end else if (idle_reg != 10'h3FF) begin
        idle_reg <= idle_reg + 10'h001;
      end
    end
  end
  // System clock rising edges seen while held in reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      edge_reg <= 11'h000;
    end else if (!in_reset) begin
      edge_reg <= 11'h000;
    end else if (sys_clk_in && !sys_reg) begin
      edge_reg <= edge_reg + 11'h001;
    end
  end
  hold_zero_a: assert property (in_reset [*2] |-> !data_out)
    else $error("serial data not zero in reset");
  halt_early_a: assert property ($rose(in_reset) |-> idle_reg >= 10'h1EA)
    else $error("reset entered before the halt span");
  halt_late_a: assert property (idle_reg >= 10'h208 |-> in_reset && powered_down)
    else $error("halted clock did not reset and power down");
  release_span_a: assert property ($fell(in_reset) |-> edge_reg inside {[11'h3FC:11'h406]})
    else $error("reset release not after the edge count");
  oe_mode_a: assert property ((!in_reset) [*2] |-> bit_clk_oe == (iface_mode_field != 2'b00))
    else $error("clock direction does not follow mode");
  oe_pair_a: assert property (bit_clk_oe == frame_clk_oe)
    else $error("bit and frame clock directions differ");
  master_sync_a: assert property (bit_clk_oe |-> !sync_lost)
    else $error("sync lost while driving own clocks");
  lost_zero_a: assert property (sync_lost [*3] |-> !data_out)
    else $error("serial data not zero while unsynchronised");
endmodule // sasp_chk

bind sasp_top sasp_chk chk (.*);

// File: verification/sasp_partner.sv
// Far-side audio processor: slave link clocks and word capture
`timescale 1ns/100ps
module sasp_partner (
  input wire logic sys_clk_in,
  input wire logic [2:0] half_edges,
  input wire logic slip,
  input wire logic format_sel,
  input wire logic bit_clk_oe,
  input wire logic bit_clk_out,
  input wire logic frame_clk_out,
  input wire logic data_out,
  output logic bit_clk_in = 1'b0,
  output logic frame_clk_in = 1'b0,
  output logic [23:0] left_word = 24'h00_0000,
  output logic [23:0] right_word = 24'h00_0000
);
  logic [2:0] sys_cnt = 3'h0;
  logic [5:0] bit_cnt = 6'h00;
  logic [5:0] slot = 6'h00;
  logic [23:0] shift = 24'h00_0000;
  logic last_frame = 1'b0;
  wire logic bclk = bit_clk_oe ? bit_clk_out : bit_clk_in;
  wire logic fclk = bit_clk_oe ? frame_clk_out : frame_clk_in;
  always @(posedge sys_clk_in) begin
    if (half_edges == 3'h0) begin
      bit_clk_in <= 1'b0;
    end else if (sys_cnt + 3'h1 >= half_edges) begin
      sys_cnt <= 3'h0;
      bit_clk_in <= !bit_clk_in;
      // Slip halves the frame so the link drifts far out of step
      if (bit_clk_in) begin
        bit_cnt <= bit_cnt + 6'h01;
        if (bit_cnt[4:0] == 5'h1F || (slip && bit_cnt[3:0] == 4'hF)) frame_clk_in <= !frame_clk_in;
      end
    end else begin
      sys_cnt <= sys_cnt + 3'h1;
    end
  end
  // Capture 24 bits a phase on rising bit clock; one slot delay in I2S
  always @(posedge bclk) begin
    if (fclk != last_frame) begin
      if (last_frame == format_sel) left_word = shift;
      else right_word = shift;
      slot = 6'h00;
      last_frame = fclk;
    end
    if (slot - {5'h00, !format_sel} < 6'h18) shift = {shift[22:0], data_out};
    if (slot != 6'h3F) slot = slot + 6'h01;
  end
endmodule // sasp_partner

// File: verification/tb.sv
// Self-checking bench for the serial audio port
`timescale 1ns/100ps
module tb;
  logic clock, rst_b, sys_clk_in, sys_en, format_sel, mute_ctrl, power_down_bit;
  logic [1:0] iface_mode_field, ratio_code;
  logic [47:0] sample_data;
  logic sample_valid, sample_ready, bit_clk_in, bit_clk_out, bit_clk_oe, slip;
  logic frame_clk_in, frame_clk_out, frame_clk_oe, data_out, filt_tick, mod_tick;
  logic sync_lost, in_reset, powered_down;
  logic [2:0] half_edges;
  logic [23:0] left_word, right_word;
  int bad_count, comparisons, sys_edges, filt_cnt, mod_cnt, bit_falls, taken;
  sasp_top #(.HOLD_FRAMES(4), .FADE_TIMEOUT_FRAMES(16)) uut (.*);
  sasp_partner lp (.*);
  // Core clock
  initial begin
    clock = 1'b0;
    forever #4 clock = !clock;
  end
  // System clock, off every core edge so sampling never races
  initial begin
    sys_clk_in = 1'b0;
    #2;
    forever #12 sys_clk_in = sys_en ? !sys_clk_in : sys_clk_in;
  end
  // Event tallies for the rate checks
  always @(posedge sys_clk_in) sys_edges++;
  always @(negedge bit_clk_out) bit_falls++;
  always @(posedge clock) begin
    filt_cnt += filt_tick;
    mod_cnt += mod_tick;
    taken += sample_valid && sample_ready;
  end
  task automatic check(input string what, input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Reset for two cycles with the mode applied meanwhile
  task automatic start(input logic [1:0] mode);
    @(negedge clock);
    rst_b = 1'b0;
    iface_mode_field = mode;
    repeat (2) @(negedge clock);
    check("reset outputs", {powered_down, in_reset, ratio_code, data_out}, 5'h1E);
    rst_b = 1'b1;
  endtask
  task automatic frame_mark;
    @(negedge frame_clk_out);
    @(posedge clock);
    #1;
  endtask
  task automatic t_master(input logic [1:0] mode, input int ratio);
    int s, f, m, b;
    start(mode);
    wait (in_reset === 1'b0);
    frame_mark;
    s = sys_edges;
    f = filt_cnt;
    m = mod_cnt;
    b = bit_falls;
    frame_mark;
    check("master oe", bit_clk_oe, 1'b1);
    check("sys per frame", sys_edges - s, ratio);
    check("bits per frame", bit_falls - b, 64);
    check("filter ticks", filt_cnt - f, 128);
    check("mod ticks", mod_cnt - m, 64);
  endtask
  task automatic t_slave;
    start(sasp_pkg::MODE_SLAVE);
    half_edges = 3'h3;
    wait (in_reset === 1'b0);
    repeat (6) @(negedge frame_clk_in);
    check("ratio", ratio_code, sasp_pkg::RATIO_384);
    check("slave oe", bit_clk_oe, 1'b0);
    @(negedge clock);
    slip = 1'b1;
    repeat (8) @(negedge frame_clk_in);
    @(negedge clock);
    check("sync lost", {sync_lost, data_out, ratio_code}, {2'b10, sasp_pkg::RATIO_384});
    slip = 1'b0;
    half_edges = 3'h0;
  endtask
  task automatic t_stream;
    int n;
    t_master(2'b11, 256);
    check("hold left", left_word, 24'h00_0000);
    @(negedge clock);
    n = taken;
    sample_valid = 1'b1;
    repeat (12) @(negedge clock);
    check("fifo accepted", taken - n, 8);
    check("fifo full", sample_ready, 1'b0);
    repeat (54) @(negedge frame_clk_out);
    check("i2s words", {left_word, right_word}, sample_data);
    @(negedge clock);
    format_sel = 1'b1;
    repeat (3) @(negedge frame_clk_out);
    check("lj words", {left_word, right_word}, sample_data);
    @(negedge clock);
    mute_ctrl = 1'b1;
    repeat (3) @(negedge frame_clk_out);
    check("mute waits", left_word, sample_data[47:24]);
    @(negedge clock);
    mute_ctrl = 1'b0;
    sample_valid = 1'b0;
    repeat (10) @(negedge frame_clk_out);
    check("drained", {left_word, right_word, sample_ready}, 49'h0_0000_0000_0001);
  endtask
  task automatic t_halt;
    @(negedge clock);
    sample_valid = 1'b1;
    power_down_bit = 1'b1;
    repeat (3) @(negedge clock);
    check("pd bit", powered_down, 1'b1);
    sys_en = 1'b0;
    repeat (600) @(negedge clock);
    check("halt reset", {in_reset, powered_down, data_out}, 3'b110);
    sys_en = 1'b1;
    power_down_bit = 1'b0;
    wait (in_reset === 1'b0);
    @(negedge clock);
    check("mode kept", bit_clk_oe, 1'b1);
    repeat (2) @(negedge frame_clk_out);
    check("zero after halt", left_word, 24'h00_0000);
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    sys_en = 1'b1;
    iface_mode_field = 2'b00;
    format_sel = 1'b0;
    mute_ctrl = 1'b0;
    power_down_bit = 1'b0;
    sample_data = 48'h8123_457E_DCBA;
    sample_valid = 1'b0;
    half_edges = 3'h0;
    slip = 1'b0;
    t_slave;
    t_master(2'b01, 512);
    t_master(2'b10, 384);
    t_stream;
    t_halt;
    complete_run;
  end
  // Watchdog; a clean run needs about 710 us
  initial begin
    #850_000;
    bad_count++;
    complete_run;
  end
endmodule // tb

// File: verilog/sasp_pkg.sv
// Constants for the stereo converter serial audio port
package sasp_pkg;
  // Core clock rate and clock-halt detection
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned HALT_NS = 4000;
  localparam int unsigned HALT_CYC = (HALT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IDLE_W = 10;
  // Reset and start-up sequencing
  localparam logic [10:0] POR_SYS_EDGES = 11'h0400;
  localparam int unsigned HOLD_FRAMES = 8960;
  localparam int unsigned FADE_TIMEOUT_FRAMES = 8192;
  localparam logic [5:0] RESYNC_FRAMES = 6'h20;
  localparam logic [5:0] FADE_STEPS = 6'h30;
  localparam int unsigned FRAME_CNT_W = 14;
  // Serial framing
  localparam int unsigned WORD_BITS = 24;
  localparam logic [4:0] LAST_BCK_HALF = 5'h1F;
  localparam int unsigned SYNC_TOL_BCK = 6;
  localparam int unsigned BCK_PER_FRAME = 64;
  // Ratio codes, shared by the mode field and the detector
  localparam logic [1:0] MODE_SLAVE = 2'b00;
  localparam logic [1:0] RATIO_512 = 2'b01;
  localparam logic [1:0] RATIO_384 = 2'b10;
  localparam logic [1:0] RATIO_256 = 2'b11;
  localparam int unsigned RATIO_512_N = 512;
  localparam int unsigned RATIO_384_N = 384;
  localparam int unsigned RATIO_256_N = 256;
  localparam logic FMT_I2S = 1'b0;
  localparam logic FMT_LJ = 1'b1;
  // Sample FIFO shape
  localparam int unsigned FIFO_WIDTH = 48;
  localparam int unsigned FIFO_DEPTH = 8;
  // Full-scale gain in Q8
  localparam logic [8:0] GAIN_FULL = 9'h100;
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } sasp_state_t;
endpackage

// File: verilog/sasp_top.sv
// Serial audio output port with ratio handling, fades, reset sequencing and FIFO
// Function
// - System clock is 256, 384 or 512 fs
// - Slave mode detects the clock ratio itself
// - Divide system clock to 128 fs; 64 fs in master mode only
// - S-shaped fades stepping on zero crossings
// - No zero crossing in 8192 frames forces fade
// - Power-on reset holds 1024 clocks, zero output
// - Then zero 8960 frames, fade in 48
// - Clock halted 4 us enters reset, zero
// - Halt reset spares mode control settings
// - Release reset 1024 clocks after resume
// - After halt release, zero 8960, fade in
// - Mode field picks slave or master ratio
// - Master drives 64 bit clocks per frame
// - Slave accepts 64, or 48 at 384
// - Format bit selects I2S or left-justified
// - Frame drift over 6 bit clocks mutes
// - Mute edges start fade-out or fade-in
`timescale 1ns/100ps

module sasp_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Storage has no reset; only pointers matter
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, count and registered flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else if (clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= (count_next != (AW + 1)'(DEPTH));
      out_valid <= (count_next != '0);
    end
  end
endmodule // sasp_fifo

module sasp_top #(
  parameter int unsigned HOLD_FRAMES = sasp_pkg::HOLD_FRAMES,
  parameter int unsigned FADE_TIMEOUT_FRAMES = sasp_pkg::FADE_TIMEOUT_FRAMES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sys_clk_in,
  input wire logic [1:0] iface_mode_field,
  input wire logic format_sel,
  input wire logic mute_ctrl,
  input wire logic power_down_bit,
  input wire logic [47:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic bit_clk_in,
  output logic bit_clk_out,
  output logic bit_clk_oe,
  input wire logic frame_clk_in,
  output logic frame_clk_out,
  output logic frame_clk_oe,
  output logic data_out,
  output logic filt_tick,
  output logic mod_tick,
  output logic [1:0] ratio_code,
  output logic sync_lost,
  output logic in_reset,
  output logic powered_down
);
  localparam int unsigned W = sasp_pkg::WORD_BITS;

  // Ratio code from sys edges per frame, within 6 bit clocks
  function automatic logic [1:0] ratio_match(input logic [9:0] cnt);
    int unsigned c;
    c = int'(cnt);
    ratio_match = sasp_pkg::MODE_SLAVE;
    if (c + sasp_pkg::SYNC_TOL_BCK * 4 >= sasp_pkg::RATIO_256_N
        && c <= sasp_pkg::RATIO_256_N + sasp_pkg::SYNC_TOL_BCK * 4) begin
      ratio_match = sasp_pkg::RATIO_256;
    end else if (c + sasp_pkg::SYNC_TOL_BCK * 6 >= sasp_pkg::RATIO_384_N
        && c <= sasp_pkg::RATIO_384_N + sasp_pkg::SYNC_TOL_BCK * 6) begin
      ratio_match = sasp_pkg::RATIO_384;
    end else if (c + sasp_pkg::SYNC_TOL_BCK * 8 >= sasp_pkg::RATIO_512_N
        && c <= sasp_pkg::RATIO_512_N + sasp_pkg::SYNC_TOL_BCK * 8) begin
      ratio_match = sasp_pkg::RATIO_512;
    end
  endfunction

  // Pseudo S-curve gain in Q8 for step 0..48
  function automatic logic [8:0] s_gain(input logic [5:0] step);
    int unsigned s;
    int unsigned g;
    s = int'(step);
    if (s <= 24) begin
      g = (s * s * 128) / 576;
    end else begin
      g = 256 - ((48 - s) * (48 - s) * 128) / 576;
    end
    s_gain = 9'(g);
  endfunction

  // Scale one channel sample by the fade gain
  function automatic logic [23:0] apply_gain(input logic [23:0] smp, input logic [8:0] g);
    logic signed [33:0] prod;
    prod = 34'($signed(smp)) * 34'($signed({1'b0, g}));
    apply_gain = prod[31:8];
  endfunction

  logic rst_s1_reg;
  logic rst_n;
  logic sys_d_reg;
  logic sys_rise;
  logic [sasp_pkg::IDLE_W-1:0] idle_reg;
  logic halted_reg;
  logic [1:0] mode_reg;
  logic fmt_reg;
  logic mute_reg;
  sasp_pkg::sasp_state_t state_reg;
  logic [10:0] por_cnt_reg;
  logic [sasp_pkg::FRAME_CNT_W-1:0] frame_cnt_reg;
  logic soft_rst;
  logic master;
  logic [1:0] eff_ratio;
  logic [2:0] half_max;
  logic [2:0] div_reg;
  logic div_wrap;
  logic [4:0] bck_half_reg;
  logic bck_lvl;
  logic frame_clk_lvl;
  logic bck_prev_reg;
  logic frame_clk_seen_reg;
  logic bck_fall;
  logic lr_change;
  logic new_left;
  logic frame_tick;
  logic [9:0] sys_per_frame_reg;
  logic [5:0] good_reg;
  logic sync_ok;
  logic [5:0] step_reg;
  logic forced_reg;
  logic [sasp_pkg::FRAME_CNT_W-1:0] nozc_reg;
  logic last_sign_reg;
  logic zero_cross;
  logic [5:0] target_step;
  logic [8:0] gain;
  logic out_en;
  logic [47:0] head_data;
  logic head_valid;
  logic [23:0] left_q;
  logic [23:0] right_q;
  logic [23:0] right_hold_reg;
  logic [23:0] shift_reg;
  logic [23:0] load_word;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  assign sys_rise = sys_clk_in && !sys_d_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_d_reg <= 1'b0;
      idle_reg <= '0;
      halted_reg <= 1'b0;
    end else begin
      sys_d_reg <= sys_clk_in;
      if (sys_rise) begin
        idle_reg <= '0;
        halted_reg <= 1'b0;
      end else if (idle_reg >= sasp_pkg::IDLE_W'(sasp_pkg::HALT_CYC - 1)) begin
        halted_reg <= 1'b1;
      end else begin
        idle_reg <= idle_reg + 1'b1;
      end
    end
  end

  // mode settings survive the halt reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= sasp_pkg::MODE_SLAVE;
      fmt_reg <= sasp_pkg::FMT_I2S;
    end else begin
      mode_reg <= iface_mode_field;
      fmt_reg <= format_sel;
    end
  end

  // reset state held for 1024 system clocks
  // zero output for 8960 frames before running
  // same hold after a halt release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sasp_pkg::ST_RESET;
      por_cnt_reg <= '0;
      frame_cnt_reg <= '0;
    end else if (halted_reg) begin
      state_reg <= sasp_pkg::ST_RESET;
      por_cnt_reg <= '0;
      frame_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        sasp_pkg::ST_RESET: begin
          if (sys_rise) begin
            por_cnt_reg <= por_cnt_reg + 1'b1;
            if (por_cnt_reg == sasp_pkg::POR_SYS_EDGES - 1'b1) begin
              state_reg <= sasp_pkg::ST_HOLD;
            end
          end
        end
        sasp_pkg::ST_HOLD: begin
          if (frame_tick) begin
            frame_cnt_reg <= frame_cnt_reg + 1'b1;
            if (frame_cnt_reg == sasp_pkg::FRAME_CNT_W'(HOLD_FRAMES - 1)) begin
              state_reg <= sasp_pkg::ST_RUN;
            end
          end
        end
        sasp_pkg::ST_RUN: begin
          state_reg <= sasp_pkg::ST_RUN;
        end
      endcase
    end
  end

  assign soft_rst = halted_reg || (state_reg == sasp_pkg::ST_RESET);

  // mode field selects slave or master ratio
  // master uses the programmed ratio only
  assign master = (mode_reg != sasp_pkg::MODE_SLAVE);
  assign eff_ratio = master ? mode_reg : ratio_code;
  // half bit clock is ratio over 128
  assign half_max = (eff_ratio == sasp_pkg::RATIO_512) ? 3'h3 :
                    (eff_ratio == sasp_pkg::RATIO_384) ? 3'h2 : 3'h1;
  assign div_wrap = sys_rise && (div_reg >= half_max);

  // 128 fs enable from the system clock; 64 fs enable in master mode only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      filt_tick <= 1'b0;
      mod_tick <= 1'b0;
    end else begin
      if (div_wrap) begin
        div_reg <= '0;
      end else if (sys_rise) begin
        div_reg <= div_reg + 1'b1;
      end
      filt_tick <= div_wrap;
      mod_tick <= div_wrap && bit_clk_out;
    end
  end

  // master bit clock with 64 per frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_clk_out <= 1'b0;
      frame_clk_out <= 1'b0;
      bit_clk_oe <= 1'b0;
      frame_clk_oe <= 1'b0;
      bck_half_reg <= '0;
    end else begin
      bit_clk_oe <= master;
      frame_clk_oe <= master;
      if (!master || soft_rst) begin
        bit_clk_out <= 1'b0;
        frame_clk_out <= fmt_reg;
        bck_half_reg <= '0;
      end else if (div_wrap) begin
        bit_clk_out <= !bit_clk_out;
        if (bit_clk_out) begin
          bck_half_reg <= bck_half_reg + 1'b1;
          if (bck_half_reg == sasp_pkg::LAST_BCK_HALF) begin
            frame_clk_out <= !frame_clk_out;
          end
        end
      end
    end
  end

  // slave takes the far party's clocks
  assign bck_lvl = master ? bit_clk_out : bit_clk_in;
  assign frame_clk_lvl = master ? frame_clk_out : frame_clk_in;
  assign bck_fall = bck_prev_reg && !bck_lvl;
  assign lr_change = bck_fall && (frame_clk_lvl != frame_clk_seen_reg);
  // left phase is low for I2S, high for left-justified
  assign new_left = (frame_clk_lvl == fmt_reg);
  assign frame_tick = lr_change && new_left;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bck_prev_reg <= 1'b0;
      frame_clk_seen_reg <= 1'b0;
    end else begin
      bck_prev_reg <= bck_lvl;
      if (bck_fall) begin
        frame_clk_seen_reg <= frame_clk_lvl;
      end
    end
  end

  // ratio detection by counting clocks per frame
  // drift beyond 6 bit clocks drops sync
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_per_frame_reg <= '0;
      ratio_code <= sasp_pkg::RATIO_256;
      good_reg <= '0;
    end else if (soft_rst) begin
      sys_per_frame_reg <= '0;
      good_reg <= '0;
    end else if (frame_tick) begin
      sys_per_frame_reg <= {9'h000, sys_rise};
      if (master) begin
        good_reg <= sasp_pkg::RESYNC_FRAMES;
      end else if (ratio_match(sys_per_frame_reg) == sasp_pkg::MODE_SLAVE) begin
        good_reg <= '0;
      end else begin
        ratio_code <= ratio_match(sys_per_frame_reg);
        if (good_reg != sasp_pkg::RESYNC_FRAMES) begin
          good_reg <= good_reg + 1'b1;
        end
      end
    end else if (sys_rise && sys_per_frame_reg != 10'h3FF) begin
      sys_per_frame_reg <= sys_per_frame_reg + 1'b1;
    end
  end

  // Resync needs 32 clean frames before output resumes
  assign sync_ok = (good_reg == sasp_pkg::RESYNC_FRAMES);

  sasp_fifo #(
    .WIDTH(sasp_pkg::FIFO_WIDTH),
    .DEPTH(sasp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .clear(soft_rst),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(head_data),
    .out_valid(head_valid),
    .out_ready(frame_tick)
  );

  // Zero crossing on the left channel sign
  assign zero_cross = head_valid && (head_data[47] != last_sign_reg);
  assign target_step = mute_reg ? 6'h00 : sasp_pkg::FADE_STEPS;

  // one gain step per zero crossing
  // timeout forces one step per frame
  // mute edges reverse the fade direction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step_reg <= '0;
      forced_reg <= 1'b1;
      nozc_reg <= '0;
      last_sign_reg <= 1'b0;
      mute_reg <= 1'b0;
    end else if (soft_rst || state_reg != sasp_pkg::ST_RUN) begin
      step_reg <= '0;
      forced_reg <= 1'b1;
      nozc_reg <= '0;
      mute_reg <= mute_ctrl;
    end else if (!sync_ok) begin
      // Loss of sync drops to mute; later fade-in waits for crossings
      step_reg <= '0;
      forced_reg <= 1'b0;
      nozc_reg <= '0;
    end else if (frame_tick) begin
      mute_reg <= mute_ctrl;
      if (mute_reg != mute_ctrl) begin
        forced_reg <= 1'b0;
        nozc_reg <= '0;
      end
      if (head_valid) begin
        last_sign_reg <= head_data[47];
      end
      if (step_reg != target_step) begin
        if (forced_reg || zero_cross) begin
          step_reg <= (step_reg < target_step) ? step_reg + 1'b1 : step_reg - 1'b1;
          nozc_reg <= '0;
        end else if (nozc_reg == sasp_pkg::FRAME_CNT_W'(FADE_TIMEOUT_FRAMES - 1)) begin
          forced_reg <= 1'b1;
        end else begin
          nozc_reg <= nozc_reg + 1'b1;
        end
      end else begin
        forced_reg <= 1'b0;
        nozc_reg <= '0;
      end
    end
  end

  // Zero data outside RUN, without sync or with no sample
  assign out_en = (state_reg == sasp_pkg::ST_RUN) && sync_ok && head_valid;
  assign gain = s_gain(step_reg);
  assign left_q = out_en ? apply_gain(head_data[47:24], gain) : 24'h00_0000;
  assign right_q = out_en ? apply_gain(head_data[23:0], gain) : 24'h00_0000;
  assign load_word = new_left ? left_q : right_hold_reg;

  // MSB first on falling bit clock, I2S delays one bit
  // left-justified puts the MSB at the frame edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      right_hold_reg <= '0;
      data_out <= 1'b0;
    end else if (soft_rst || !sync_ok) begin // Sync loss zeroes the word at once
      shift_reg <= '0;
      right_hold_reg <= '0;
      data_out <= 1'b0;
    end else if (lr_change) begin
      if (new_left) begin
        right_hold_reg <= right_q;
      end
      if (fmt_reg == sasp_pkg::FMT_LJ) begin
        data_out <= load_word[W-1];
        shift_reg <= {load_word[W-2:0], 1'b0};
      end else begin
        data_out <= 1'b0;
        shift_reg <= load_word;
      end
    end else if (bck_fall) begin
      // Bits past the 24th read as zero
      data_out <= shift_reg[W-1];
      shift_reg <= {shift_reg[W-2:0], 1'b0};
    end
  end

  // power-down on the bit or on clock halt
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      powered_down <= 1'b1;
      in_reset <= 1'b1;
      sync_lost <= 1'b0;
    end else begin
      powered_down <= halted_reg || power_down_bit;
      in_reset <= soft_rst;
      sync_lost <= (state_reg == sasp_pkg::ST_RUN) && !sync_ok;
    end
  end
endmodule // sasp_top
